// *** logic/umd_top.sv ***
// Multidrop UART with driver enable and divisor timer
// Function
// - Ninth bit carries address flag
// - Mode 01 interrupts on address bytes only
// - Mode 00 interrupts on every byte
// - Clearing nine bit enable interrupts all
// - Ninth bit flag reports received address
// - Mode 10 drops mismatched frames
// - Match and following data interrupt
// - First data byte flagged new frame
// - Each address byte is recompared
// - Mode 11 no address interrupts
// - Drive enable covers whole frame
// - Drive enable leads start by one to two bits
// - Deassert one clock after stop
// - Polarity bit inverts drive enable
// - Holding empty after first bit sent
// - Receive interrupt data or errors
// - Overrun keeps unread byte, hides status
// - Post overrun after good byte read
// - Second read clears error status
// - Timer interrupt on divisor reload
// - Rate is clock over 16 divisor
// - Idle divisor counter works as timer
`default_nettype none
module umd_top (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Configuration
  input  wire logic        i_transmitter_on,
  input  wire logic        i_receiver_on,
  input  wire logic        i_nine_bit_enable,
  input  wire logic [1:0]  i_mp_interrupt_select,
  input  wire logic        i_tx_ninth_bit,
  input  wire logic        i_drive_enable_polarity,
  input  wire logic        i_divisor_timer_enable,
  input  wire logic        i_rx_data_irq_enable,
  input  wire logic [15:0] i_baud_divisor_value,
  input  wire logic [7:0]  i_node_address,
  // Transmit data write
  input  wire logic        i_tx_wr,
  input  wire logic [7:0]  i_tx_data,
  // Receive data read
  input  wire logic        i_rx_rd,
  output logic [7:0]       o_rx_data,
  // Status
  output logic             o_tx_holding_empty,
  output logic             o_rx_byte_available,
  output logic             o_overrun,
  output logic             o_line_break_seen,
  output logic             o_framing_error,
  output logic             o_rx_ninth_bit_flag,
  output logic             o_first_data_of_frame,
  // Interrupts
  output logic             o_tx_irq,
  output logic             o_rx_irq,
  // Serial line
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_transceiver_drive_enable
);
  logic reload;
  umd_brg umd_brg_inst (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_divisor (i_baud_divisor_value),
    .o_reload  (reload)
  );
  wire uart_idle  = !i_transmitter_on && !i_receiver_on;
  wire timer_irq  = i_divisor_timer_enable && reload && uart_idle;

  // Transmitter
  umd_pkg::umd_tx_state_e tx_st_q;
  logic [3:0]  tx_ovs_q;
  logic [3:0]  tx_bit_q;
  logic [8:0]  tx_sh_q;
  logic [8:0]  hold_q;
  logic        hold_full_q;
  logic        txd_q;
  logic        de_q;
  wire         tx_tick     = reload && (tx_ovs_q == umd_pkg::OVS_LAST);
  wire         tx_bit_done = tx_tick;
  wire [8:0]   tx_word     = {i_tx_ninth_bit && i_nine_bit_enable, i_tx_data};
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_st_q     <= umd_pkg::TX_IDLE;
      tx_ovs_q    <= 4'h0;
      tx_bit_q    <= 4'h0;
      tx_sh_q     <= 9'h000;
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
      txd_q       <= 1'b1;
      de_q        <= 1'b0;
    end else begin
      if (reload) begin
        tx_ovs_q <= tx_ovs_q + 4'h1;
      end
      if (i_tx_wr) begin
        hold_q      <= tx_word;
        hold_full_q <= 1'b1;
      end
      case (tx_st_q)
        umd_pkg::TX_IDLE: begin
          txd_q <= 1'b1;
          if ((hold_full_q || i_tx_wr) && i_transmitter_on) begin
            de_q     <= 1'b1;
            tx_bit_q <= 4'h0;
            tx_st_q  <= umd_pkg::TX_LEAD;
          end else begin
            de_q <= 1'b0;
          end
        end
        umd_pkg::TX_LEAD: begin
          // Partial grid slot plus one whole bit keeps the lead in one to two bits
          if (tx_bit_done && (tx_bit_q == 4'h0)) begin
            tx_bit_q <= 4'h1;
          end else if (tx_bit_done) begin
            tx_st_q <= umd_pkg::TX_START;
            txd_q   <= 1'b0;
            tx_sh_q <= hold_q;
          end
        end
        umd_pkg::TX_START: begin
          if (tx_bit_done) begin
            if (!i_tx_wr) begin
              hold_full_q <= 1'b0;
            end
            txd_q    <= tx_sh_q[0];
            tx_bit_q <= 4'h1;
            tx_st_q  <= umd_pkg::TX_DATA;
          end
        end
        umd_pkg::TX_DATA: begin
          if (tx_bit_done) begin
            if (tx_bit_q == umd_pkg::BITS_DATA) begin
              txd_q   <= i_nine_bit_enable ? tx_sh_q[8] : 1'b1;
              tx_st_q <= i_nine_bit_enable ? umd_pkg::TX_NINTH : umd_pkg::TX_STOP;
            end else begin
              txd_q    <= tx_sh_q[tx_bit_q];
              tx_bit_q <= tx_bit_q + 4'h1;
            end
          end
        end
        umd_pkg::TX_NINTH: begin
          if (tx_bit_done) begin
            txd_q   <= 1'b1;
            tx_st_q <= umd_pkg::TX_STOP;
          end
        end
        default: begin
          if (tx_bit_done) begin
            txd_q <= 1'b1;
            if (hold_full_q) begin
              tx_st_q <= umd_pkg::TX_START;
              txd_q   <= 1'b0;
              tx_sh_q <= hold_q;
            end else begin
              tx_st_q <= umd_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign o_txd                      = txd_q;
  assign o_tx_holding_empty         = !hold_full_q;
  assign o_tx_irq                   = !hold_full_q && i_transmitter_on;
  assign o_transceiver_drive_enable = de_q ^ i_drive_enable_polarity;

  // Receiver
  umd_pkg::umd_rx_state_e rx_st_q;
  logic [3:0]  rx_ovs_q;
  logic [3:0]  rx_bit_q;
  logic [8:0]  rx_sh_q;
  logic        rx_allzero_q;
  logic [7:0]  rx_data_q;
  logic        avail_q;
  logic        ovr_pend_q;
  logic        brk_pend_q;
  logic        ovr_q;
  logic        brk_q;
  logic        fe_q;
  logic        ninth_q;
  logic        first_data_of_frame_q;
  logic        matched_q;
  logic        first_pend_q;
  logic        irq_q;
  wire         rx_sample = reload && (rx_ovs_q == umd_pkg::OVS_MID);
  wire         rx_done   = rx_sample && (rx_st_q == umd_pkg::RX_STOP);
  wire         rx_brk    = rx_done && rx_allzero_q && !i_rxd;
  wire         rx_addr   = i_nine_bit_enable && rx_sh_q[8];
  wire         addr_hit  = (rx_sh_q[7:0] == i_node_address);
  wire         hw_cmp    = i_nine_bit_enable && i_mp_interrupt_select[1];
  // Byte acceptance and interrupt selection per multidrop scheme
  wire         accept    = !hw_cmp || (rx_addr ? addr_hit : matched_q);
  wire         keep_data = !hw_cmp || !rx_addr || (i_mp_interrupt_select == umd_pkg::MP_MATCH);
  wire         want_irq  = !i_nine_bit_enable ||
                           (i_mp_interrupt_select == umd_pkg::MP_ALL) ||
                           (i_mp_interrupt_select == umd_pkg::MP_ADDR ? rx_addr
                                                                      : keep_data);
  wire         deliver   = rx_done && accept && keep_data;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rx_st_q      <= umd_pkg::RX_IDLE;
      rx_ovs_q     <= 4'h0;
      rx_bit_q     <= 4'h0;
      rx_sh_q      <= 9'h000;
      rx_allzero_q <= 1'b0;
      rx_data_q    <= 8'h00;
      avail_q      <= 1'b0;
      ovr_pend_q   <= 1'b0;
      brk_pend_q   <= 1'b0;
      ovr_q        <= 1'b0;
      brk_q        <= 1'b0;
      fe_q         <= 1'b0;
      ninth_q      <= 1'b0;
      first_data_of_frame_q     <= 1'b0;
      matched_q    <= 1'b0;
      first_pend_q <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      if (reload) begin
        rx_ovs_q <= rx_ovs_q + 4'h1;
      end
      case (rx_st_q)
        umd_pkg::RX_IDLE: begin
          if (i_receiver_on && !i_rxd) begin
            rx_st_q      <= umd_pkg::RX_START;
            rx_ovs_q     <= 4'h0;
            rx_allzero_q <= 1'b1;
          end
        end
        umd_pkg::RX_START: begin
          if (rx_sample) begin
            rx_st_q  <= i_rxd ? umd_pkg::RX_IDLE : umd_pkg::RX_DATA;
            rx_bit_q <= 4'h0;
          end
        end
        umd_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_sh_q      <= {1'b0, i_rxd, rx_sh_q[7:1]};
            rx_allzero_q <= rx_allzero_q && !i_rxd;
            rx_bit_q     <= rx_bit_q + 4'h1;
            if (rx_bit_q == umd_pkg::BITS_DATA - 4'h1) begin
              rx_st_q <= i_nine_bit_enable ? umd_pkg::RX_NINTH : umd_pkg::RX_STOP;
            end
          end
        end
        umd_pkg::RX_NINTH: begin
          if (rx_sample) begin
            rx_sh_q[8]   <= i_rxd;
            rx_allzero_q <= rx_allzero_q && !i_rxd;
            rx_st_q      <= umd_pkg::RX_STOP;
          end
        end
        default: begin
          if (rx_sample) begin
            rx_st_q <= umd_pkg::RX_IDLE;
          end
        end
      endcase
      if (rx_done && hw_cmp && rx_addr) begin
        matched_q    <= addr_hit;
        first_pend_q <= addr_hit;
      end
      // Overrun sequencing and second read clearing error bits
      if (i_rx_rd) begin
        if (ovr_pend_q) begin
          ovr_q      <= 1'b1;
          brk_q      <= brk_pend_q;
          avail_q    <= 1'b1;
          ovr_pend_q <= 1'b0;
          brk_pend_q <= 1'b0;
        end else begin
          ovr_q   <= 1'b0;
          brk_q   <= 1'b0;
          fe_q    <= 1'b0;
          avail_q <= 1'b0;
        end
      end
      if (deliver) begin
        if (avail_q && !i_rx_rd) begin
          ovr_pend_q <= 1'b1;
          brk_pend_q <= brk_pend_q || rx_brk;
        end else begin
          rx_data_q <= rx_sh_q[7:0];
          avail_q   <= 1'b1;
          brk_q     <= rx_brk;
          fe_q      <= !i_rxd;
          ninth_q   <= rx_sh_q[8];
          first_data_of_frame_q  <= hw_cmp && !rx_addr && first_pend_q;
          if (hw_cmp && !rx_addr) begin
            first_pend_q <= 1'b0;
          end
        end
      end
      irq_q <= deliver && want_irq && i_rx_data_irq_enable;
    end
  end
  assign o_rx_data             = rx_data_q;
  assign o_rx_byte_available   = avail_q;
  assign o_overrun             = ovr_q;
  assign o_line_break_seen     = brk_q;
  assign o_framing_error       = fe_q;
  assign o_rx_ninth_bit_flag   = ninth_q;
  assign o_first_data_of_frame = first_data_of_frame_q;
  assign o_rx_irq              = irq_q || ovr_q || brk_q || fe_q || timer_irq;
endmodule : umd_top
`default_nettype wire

// *** logic/umd_pkg.sv ***
// Package with constants and types for the multidrop UART
`default_nettype none
package umd_pkg;
  localparam logic [1:0] MP_ALL      = 2'h0;
  localparam logic [1:0] MP_ADDR     = 2'h1;
  localparam logic [1:0] MP_MATCH    = 2'h2;
  localparam logic [1:0] MP_DATAONLY = 2'h3;
  localparam logic [15:0] DIV_RESET   = 16'h0001;
  localparam logic [3:0]  OVS_LAST    = 4'hF;
  localparam logic [3:0]  OVS_MID     = 4'h7;
  localparam logic [3:0]  BITS_DATA   = 4'h8;
  localparam logic [7:0]  ADDR_RESET  = 8'h00;
  typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_NINTH, TX_STOP}
    umd_tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} umd_rx_state_e;
endpackage : umd_pkg
`default_nettype wire

// *** logic/umd_brg.sv ***
// Baud divisor counter with reload pulse and 16x tick
`default_nettype none
module umd_brg (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Divisor
  input  wire logic [15:0] i_divisor,
  // Reload pulse
  output logic             o_reload
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  wire         term = (cnt_q <= 16'h0001);
  assign cnt_d    = term ? i_divisor : cnt_q - 16'h0001;
  assign o_reload = term;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_q <= umd_pkg::DIV_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : umd_brg
`default_nettype wire

// *** testbench/umd_top_monitor.sv ***
// Checker for the multidrop UART top ports
`default_nettype none
module umd_top_monitor (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // Watched ports
  input wire logic        i_tx_wr,
  input wire logic        i_rx_rd,
  input wire logic        i_drive_enable_polarity,
  input wire logic [15:0] i_baud_divisor_value,
  input wire logic        o_txd,
  input wire logic        o_transceiver_drive_enable,
  input wire logic        o_tx_holding_empty,
  input wire logic        o_overrun,
  input wire logic        o_rx_irq,
  input wire logic [7:0]  o_rx_data,
  input wire logic        o_rx_byte_available
);
  wire         de_act = o_transceiver_drive_enable ^ i_drive_enable_polarity;
  logic [19:0] lead_q;
  logic        low_q;
  // Clocks of drive enable before the first start bit
  always_ff @(posedge i_mclk) begin
    lead_q <= (i_rst || !de_act) ? 20'h0 : lead_q + {19'h0, !low_q};
    low_q  <= (i_rst || !de_act) ? 1'b0 : low_q | !o_txd;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_de_on_write: assert property (i_tx_wr && !de_act |=> de_act)
    else $error("drive enable missed a write");
  a_lead_window: assert property (de_act && !low_q && !o_txd |->
    lead_q >= {i_baud_divisor_value, 4'h0} && lead_q <= {i_baud_divisor_value, 5'h0})
    else $error("lead time outside one to two bits");
  a_low_in_frame: assert property (!o_txd |-> de_act)
    else $error("line low outside drive enable");
  a_de_drop_idle: assert property ($fell(de_act) |-> o_txd && $past(o_txd))
    else $error("drive enable dropped inside a frame");
  a_reset_level: assert property ($fell(i_rst) |-> !de_act && o_txd)
    else $error("bad drive enable level after reset");
  a_wr_fills: assert property (i_tx_wr |=> !o_tx_holding_empty)
    else $error("holding empty after write");
  a_empty_after_start: assert property ($rose(o_tx_holding_empty) |->
    de_act && (!$past(o_txd) || !$past(o_txd, 2)))
    else $error("holding empty not at start bit");
  a_ovr_on_read: assert property ($rose(o_overrun) |-> $past(i_rx_rd))
    else $error("overrun shown before read");
  a_ovr_clear: assert property (o_overrun && i_rx_rd |=> !o_overrun)
    else $error("overrun not cleared by read");
  a_data_held: assert property ($changed(o_rx_data) |->
    $rose(o_rx_byte_available) || $past(i_rx_rd))
    else $error("receive data changed with no new byte");
  a_err_irq: assert property (o_overrun && $past(o_overrun) |-> o_rx_irq)
    else $error("error without receive interrupt");
endmodule : umd_top_monitor
bind umd_top umd_top_monitor umd_top_monitor_inst (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_tx_wr(i_tx_wr), .i_rx_rd(i_rx_rd),
  .i_drive_enable_polarity(i_drive_enable_polarity),
  .i_baud_divisor_value(i_baud_divisor_value), .o_txd(o_txd),
  .o_transceiver_drive_enable(o_transceiver_drive_enable),
  .o_tx_holding_empty(o_tx_holding_empty), .o_overrun(o_overrun), .o_rx_irq(o_rx_irq),
  .o_rx_data(o_rx_data), .o_rx_byte_available(o_rx_byte_available));
`default_nettype wire

// *** testbench/umd_remote_node.sv ***
// Remote node model driving the shared serial line
`default_nettype none
module umd_remote_node #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic i_mclk,
  // Line toward the UART, pulled up when idle
  output var logic  o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_line = 1'b1;
  // Start, data LSB first, optional ninth bit, one stop bit
  task automatic send(input logic [7:0] d, input logic nbon, input logic nb, input logic stp);
    logic [10:0] f;
    f = nbon ? {stp, nb, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (nbon ? 11 : 10); i++) begin
      o_line <= f[i];
      repeat (BIT_CLKS) @(posedge i_mclk);
    end
    o_line <= 1'b1;
  endtask : send
endmodule : umd_remote_node
`default_nettype wire

// *** testbench/tb_uart_multidrop_de_brg.sv ***
// Testbench for the multidrop UART
`default_nettype none
module tb_uart_multidrop_de_brg;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, ton, ron, nbe, tnb, pol, tmr, dirq, wr, rd, rxd, txd, de;
  logic hemp, avl, ovr, brk, ferr, nfl, fst, tirq, rirq;
  logic [1:0] mode;
  logic [15:0] div;
  logic [7:0] addr, td, rdat;
  logic [2:0] lastf;
  int n_errors = 0, n_tests = 0, n_irq = 0, cyc = 0;
  umd_top umd_top_inst (.i_mclk(clk), .i_rst(rst), .i_transmitter_on(ton),
    .i_receiver_on(ron), .i_nine_bit_enable(nbe), .i_mp_interrupt_select(mode),
    .i_tx_ninth_bit(tnb), .i_drive_enable_polarity(pol), .i_divisor_timer_enable(tmr),
    .i_rx_data_irq_enable(dirq), .i_baud_divisor_value(div), .i_node_address(addr),
    .i_tx_wr(wr), .i_tx_data(td), .i_rx_rd(rd), .o_rx_data(rdat),
    .o_tx_holding_empty(hemp), .o_rx_byte_available(avl), .o_overrun(ovr),
    .o_line_break_seen(brk), .o_framing_error(ferr), .o_rx_ninth_bit_flag(nfl),
    .o_first_data_of_frame(fst), .o_tx_irq(tirq), .o_rx_irq(rirq), .i_rxd(rxd),
    .o_txd(txd), .o_transceiver_drive_enable(de));
  umd_remote_node #(.BIT_CLKS(16)) umd_remote_node_inst (.i_mclk(clk), .o_line(rxd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (rirq === 1'b1) n_irq++;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_byte(input logic [7:0] d, input logic nb);
    td <= d;
    tnb <= nb;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_byte
  task automatic rd_byte;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rd_byte
  task automatic get_frame(output logic [9:0] v);
    while (txd !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge clk);
      v[i] = txd;
    end
  endtask : get_frame
  task automatic node(input logic [7:0] d, input logic nb);
    umd_remote_node_inst.send(d, 1'b1, nb, 1'b1);
    repeat (20) @(posedge clk);
    lastf = {avl, nfl, fst};
    if (avl === 1'b1) rd_byte();
  endtask : node
  task automatic t_tx;
    logic [9:0] a, b;
    fork
      begin get_frame(a); get_frame(b); end
      begin
        wr_byte(8'hA5, 1'b1);
        chk(16'({hemp, tirq}), 16'h0);
        while (hemp !== 1'b1) @(posedge clk);
        chk(16'({de, tirq}), 16'h1);
        wr_byte(8'h3C, 1'b0);
      end
    join
    chk(16'(a), 16'h03A5);
    chk(16'(b), 16'h023C);
    repeat (40) @(posedge clk);
    chk(16'(de), 16'h1);
  endtask : t_tx
  task automatic t_mode;
    int exp [4] = '{4, 2, 2, 1};
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      repeat (2) @(posedge clk);
      n_irq = 0;
      node(8'h11, 1'b1);
      node(8'h22, 1'b0);
      node(8'h5A, 1'b1);
      if (m < 3) chk(16'(lastf[2:1]), 16'h3);
      node(8'h33, 1'b0);
      chk(16'(n_irq), 16'(exp[m]));
      if (m > 1) chk(16'(lastf), 16'h5);
    end
  endtask : t_mode
  task automatic t_ovr;
    nbe <= 1'b0;
    dirq <= 1'b0;
    n_irq = 0;
    umd_remote_node_inst.send(8'hC3, 1'b0, 1'b0, 1'b1);
    umd_remote_node_inst.send(8'h00, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    chk(16'(n_irq), 16'h0);
    chk({6'h0, ovr, brk, rdat}, 16'h00C3);
    rd_byte();
    chk(16'({avl, ovr, brk}), 16'h7);
    rd_byte();
    chk(16'({ovr, brk}), 16'h0);
    umd_remote_node_inst.send(8'h81, 1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    chk(16'({ferr, rirq, brk, rdat}), 16'h0681);
    rd_byte();
    chk(16'({avl, ferr, rirq}), 16'h0);
  endtask : t_ovr
  task automatic t_timer;
    int k;
    k = 0;
    ton <= 1'b0;
    ron <= 1'b0;
    tmr <= 1'b1;
    div <= 16'h0005;
    repeat (10) @(posedge clk);
    repeat (100) begin
      @(posedge clk);
      if (rirq === 1'b1) k++;
    end
    chk(16'(k), 16'd20);
  endtask : t_timer
  initial begin
    {rst, ton, ron, nbe, dirq} = 5'h1F;
    {tnb, pol, tmr, wr, rd, mode} = 7'h00;
    div = 16'h0001;
    addr = 8'h5A;
    td = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    pol <= 1'b1;
    repeat (3) @(posedge clk);
    t_tx();
    pol <= 1'b0;
    t_mode();
    t_ovr();
    t_timer();
    wrap_up();
  end
endmodule : tb_uart_multidrop_de_brg
`default_nettype wire
